//--- logic/mdg_defines.vh
// constants for the serial diagnostic and address map block
`ifndef MDG_DEFINES_VH
`define MDG_DEFINES_VH

// function codes
`define MDG_FC_RD_COILS     8'h01
`define MDG_FC_RD_INPUTS    8'h02
`define MDG_FC_RD_HOLDING   8'h03
`define MDG_FC_RD_INREG     8'h04
`define MDG_FC_WR_COIL      8'h05
`define MDG_FC_WR_REG       8'h06
`define MDG_FC_DIAG         8'h08
`define MDG_FC_WR_COILS     8'h0F
`define MDG_FC_WR_REGS      8'h10

// diagnostic subfunctions
`define MDG_SF_ECHO         16'h0000
`define MDG_SF_SER_DIAG     16'h0002
`define MDG_SF_CLEAR        16'h000A
`define MDG_SF_BUS_MSG      16'h000B
`define MDG_SF_COMM_ERR     16'h000C
`define MDG_SF_EXC_CNT      16'h000D
`define MDG_SF_SLAVE_MSG    16'h000E
`define MDG_SF_NO_RESP      16'h000F
`define MDG_SF_SER_OVR      16'h0012
`define MDG_SF_NET_STATE    16'h001F
`define MDG_SF_NET_FAULTS   16'h0020
`define MDG_SF_CAN_ERR      16'h0021
`define MDG_SF_CAN_BUSOFF   16'h0022
`define MDG_SF_CAN_OVR      16'h0023

// reference number ranges
`define MDG_REF_COIL_LO     16'h0001
`define MDG_REF_COIL_HI     16'h270F
`define MDG_REF_INPUT_LO    16'h2711
`define MDG_REF_INPUT_HI    16'h4E1F
`define MDG_REF_INREG_LO    16'h7531
`define MDG_REF_INREG_HI    16'h7930
`define MDG_REF_HOLD_LO     16'h9C41
`define MDG_REF_HOLD_HI     16'hA040
`define MDG_REF_DIAG_LO     16'h7D01
`define MDG_REF_DIAG_HI     16'h7D0C
`define MDG_REF_CLEAR       16'hA411

// diagnostic word indices
`define MDG_IDX_SER_DIAG    4'h0
`define MDG_IDX_NET_STATE   4'h7
`define MDG_IDX_NET_FAULTS  4'h8
`define MDG_IDX_NONE        4'hF

// serial diagnostic word bit positions
`define MDG_SD_ACTIVE       0
`define MDG_SD_MASTER       1
`define MDG_SD_RUN          2
`define MDG_SD_OVERRUN      3
`define MDG_SD_PARITY       4
`define MDG_SD_FRAMING      5
`define MDG_SD_CRC          6

// fault word bit positions
`define MDG_FW_CLAIM        0
`define MDG_FW_WARN         1
`define MDG_FW_BUSOFF       2
`define MDG_FW_CAN_OVR      3
`define MDG_FW_TP_ERR       4
`define MDG_FW_RXQ_OVF      5
`define MDG_FW_TXQ_OVF      6

// counter count and exception codes
`define MDG_NUM_CNT         9
`define MDG_CNT_W           16
`define MDG_EXC_FUNC        8'h01
`define MDG_EXC_ADDR        8'h02
`define MDG_ZERO16          16'h0000

`endif

//--- logic/mdg_evt_cnt.v
// one 16-bit diagnostic event counter with clear
`timescale 1ns/1ns
`include "mdg_defines.vh"

module mdg_evt_cnt (
	input  wire        i_mclk,
	input  wire        i_reset,
	input  wire        i_ce,
	input  wire        i_clear,
	input  wire        i_event,
	output reg  [15:0] o_count
);

	// clear zeroes, an event in the clear cycle still counts
	always @(posedge i_mclk) begin
		if (i_reset) begin
			o_count <= 16'h0000;
		end else if (i_ce) begin
			if (i_clear) begin
				o_count <= {15'h0000, i_event};
			end else if (i_event) begin
				o_count <= o_count + 16'h0001;
			end
		end
	end

endmodule

//--- logic/mdg_diag_map.v
// diagnostic function decoder, link counters, status words and table address map
// Functional notes
// - subfunction 0 echoes the request data word unchanged
// - subfunction 2 returns the serial link diagnostic word
// - subfunction 10 zeroes counters and sticky serial bits, clears latched faults
// - subfunction 11 returns count of every frame seen on the bus
// - subfunction 12 returns CRC failures in frames addressed to us
// - subfunction 13 returns count of exception responses sent
// - subfunction 14 returns count of frames carrying our slave address
// - subfunction 15 returns count of requests left without response
// - subfunction 18 returns serial character overrun count
// - subfunctions 31 and 32 return network state and fault words
// - subfunction 33 returns count of CAN error warning crossings
// - subfunction 34 returns count of CAN bus-off entries
// - subfunction 35 returns count of CAN receive overruns
// - serial word bits 0,1,2: active, master alive, run mode
// - serial word bits 3-6 latch overrun, parity, framing, CRC; 7-15 zero
// - network state word: 0 offline, 1 online, 2 initializing
// - fault bit 0 shows failed unique address claim
// - fault bits 1-6 latch CAN and queue faults until reset or clear; 7-15 zero
// - coils and holding registers use output table, others input table
// - addresses outside configured table space get an exception response
// - register n maps to byte offset 2*(n-1), up to 2046
// - bit n maps to byte (n-1)/8, bit (n-1)%8
// - input registers 32001 to 32012 read the diagnostic words
// - write to holding register 42001 performs the clear action
`timescale 1ns/1ns
`include "mdg_defines.vh"

module mdg_diag_map (
	input  wire        i_mclk,
	input  wire        i_reset,
	input  wire        i_ce,
	// decoded request from the frame layer
	input  wire        i_req_valid,
	input  wire [7:0]  i_req_func,
	input  wire [15:0] i_req_ref,
	input  wire [15:0] i_req_sub,
	input  wire [15:0] i_req_data,
	// configured table sizes in bytes
	input  wire [11:0] i_in_size,
	input  wire [11:0] i_out_size,
	// link event pulses
	input  wire        i_frame_seen,
	input  wire        i_own_frame,
	input  wire        i_crc_err_own,
	input  wire        i_exc_sent,
	input  wire        i_no_resp,
	input  wire        i_ser_overrun,
	input  wire        i_parity_err,
	input  wire        i_framing_err,
	// vehicle network event pulses
	input  wire        i_can_warn,
	input  wire        i_can_busoff,
	input  wire        i_can_overrun,
	input  wire        i_tp_err,
	input  wire        i_rxq_ovf,
	input  wire        i_txq_ovf,
	// status levels
	input  wire        i_active,
	input  wire        i_master_alive,
	input  wire        i_run_mode,
	input  wire [1:0]  i_net_state,
	input  wire        i_claim_failed,
	// answer
	output wire        o_rsp_valid,
	output reg         o_rsp_exc,
	output reg  [7:0]  o_rsp_exc_code,
	output reg  [15:0] o_rsp_data,
	output reg         o_tbl_hit,
	output reg         o_tbl_output,
	output reg         o_tbl_word,
	output reg         o_tbl_write,
	output reg  [10:0] o_tbl_byte,
	output reg  [2:0]  o_tbl_bit,
	output reg         o_clear_done,
	// status words for observation
	output wire [15:0] o_serial_link_diagnostics,
	output wire [15:0] o_vehicle_net_state,
	output wire [15:0] o_vehicle_net_faults
);

	reg         rsp_valid;
	reg  [3:0]  ser_sticky;
	reg  [5:0]  fault_sticky;
	wire [143:0] cnt_bus;
	wire [8:0]  cnt_evt;
	wire        req;
	wire        clear_req;

	// combinational decode results
	reg         next_exc;
	reg  [7:0]  next_exc_code;
	reg  [15:0] next_data;
	reg         next_hit;
	reg         next_output;
	reg         next_word;
	reg         next_write;
	reg  [10:0] next_byte;
	reg  [2:0]  next_bit;
	reg  [3:0]  diag_idx;
	reg  [15:0] offs;

	assign req = i_req_valid & i_ce;

	// reference inside an inclusive range
	function in_range;
		input [15:0] ref_num;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (ref_num >= lo) && (ref_num <= hi);
		end
	endfunction

	// one counter out of the bank
	function [15:0] cnt_sel;
		input [143:0] bank;
		input [3:0]   n;
		begin
			cnt_sel = bank[n*16 +: 16];
		end
	endfunction

	// subfunction to diagnostic word index
	function [3:0] sub_idx;
		input [15:0] sub;
		begin
			case (sub)
				`MDG_SF_SER_DIAG:   sub_idx = 4'h0;
				`MDG_SF_BUS_MSG:    sub_idx = 4'h1;
				`MDG_SF_COMM_ERR:   sub_idx = 4'h2;
				`MDG_SF_EXC_CNT:    sub_idx = 4'h3;
				`MDG_SF_SLAVE_MSG:  sub_idx = 4'h4;
				`MDG_SF_NO_RESP:    sub_idx = 4'h5;
				`MDG_SF_SER_OVR:    sub_idx = 4'h6;
				`MDG_SF_NET_STATE:  sub_idx = 4'h7;
				`MDG_SF_NET_FAULTS: sub_idx = 4'h8;
				`MDG_SF_CAN_ERR:    sub_idx = 4'h9;
				`MDG_SF_CAN_BUSOFF: sub_idx = 4'hA;
				`MDG_SF_CAN_OVR:    sub_idx = 4'hB;
				default:            sub_idx = `MDG_IDX_NONE;
			endcase
		end
	endfunction

	// diagnostic word by index, same order as the register window
	function [15:0] diag_word;
		input [3:0]   n;
		input [143:0] bank;
		input [15:0]  ser;
		input [15:0]  st;
		input [15:0]  flt;
		begin
			case (n)
				4'h0:    diag_word = ser;
				4'h1:    diag_word = cnt_sel(bank, 4'h0);
				4'h2:    diag_word = cnt_sel(bank, 4'h1);
				4'h3:    diag_word = cnt_sel(bank, 4'h2);
				4'h4:    diag_word = cnt_sel(bank, 4'h3);
				4'h5:    diag_word = cnt_sel(bank, 4'h4);
				4'h6:    diag_word = cnt_sel(bank, 4'h5);
				4'h7:    diag_word = st;
				4'h8:    diag_word = flt;
				4'h9:    diag_word = cnt_sel(bank, 4'h6);
				4'hA:    diag_word = cnt_sel(bank, 4'h7);
				4'hB:    diag_word = cnt_sel(bank, 4'h8);
				default: diag_word = `MDG_ZERO16;
			endcase
		end
	endfunction

	// clear by subfunction 10 or by write to the clear register
	assign clear_req = req & (((i_req_func == `MDG_FC_DIAG) && (i_req_sub == `MDG_SF_CLEAR))
		| (((i_req_func == `MDG_FC_WR_REG) || (i_req_func == `MDG_FC_WR_REGS))
		&& (i_req_ref == `MDG_REF_CLEAR)));

	// event vector into the counter bank
	assign cnt_evt = {i_can_overrun, i_can_busoff, i_can_warn, i_ser_overrun, i_no_resp,
		i_own_frame, i_exc_sent, i_crc_err_own, i_frame_seen};

	genvar gi;
	generate
		for (gi = 0; gi < `MDG_NUM_CNT; gi = gi + 1) begin : g_cnt
			mdg_evt_cnt u_cnt (
				.i_mclk  (i_mclk),
				.i_reset (i_reset),
				.i_ce    (i_ce),
				.i_clear (clear_req),
				.i_event (cnt_evt[gi]),
				.o_count (cnt_bus[gi*16 +: 16])
			);
		end
	endgenerate

	// sticky serial fault bits, event wins over clear
	always @(posedge i_mclk) begin
		if (i_reset) begin
			ser_sticky <= 4'h0;
		end else if (i_ce) begin
			ser_sticky <= (clear_req ? 4'h0 : ser_sticky)
				| {i_crc_err_own, i_framing_err, i_parity_err, i_ser_overrun};
		end
	end

	// sticky vehicle network faults held until a fault reset
	always @(posedge i_mclk) begin
		if (i_reset) begin
			fault_sticky <= 6'h00;
		end else if (i_ce) begin
			fault_sticky <= (clear_req ? 6'h00 : fault_sticky)
				| {i_txq_ovf, i_rxq_ovf, i_tp_err, i_can_overrun, i_can_busoff,
				i_can_warn};
		end
	end

	// status words, unused upper bits read zero
	assign o_serial_link_diagnostics = {9'h000, ser_sticky, i_run_mode, i_master_alive,
		i_active};
	assign o_vehicle_net_state  = {14'h0000, i_net_state};
	assign o_vehicle_net_faults = {9'h000, fault_sticky, i_claim_failed};

	// request decode
	always @* begin
		next_exc      = 1'b0;
		next_exc_code = 8'h00;
		next_data     = `MDG_ZERO16;
		next_hit      = 1'b0;
		next_output   = 1'b0;
		next_word     = 1'b0;
		next_write    = 1'b0;
		next_byte     = 11'h000;
		next_bit      = 3'h0;
		diag_idx      = `MDG_IDX_NONE;
		offs          = `MDG_ZERO16;
		case (i_req_func)
			`MDG_FC_DIAG: begin
				if (i_req_sub == `MDG_SF_ECHO) begin
					next_data = i_req_data;
				end else if (i_req_sub == `MDG_SF_CLEAR) begin
					next_data = i_req_data;
				end else begin
					diag_idx = sub_idx(i_req_sub);
					if (diag_idx == `MDG_IDX_NONE) begin
						next_exc      = 1'b1;
						next_exc_code = `MDG_EXC_FUNC;
					end else begin
						next_data = diag_word(diag_idx, cnt_bus, o_serial_link_diagnostics,
							o_vehicle_net_state, o_vehicle_net_faults);
					end
				end
			end
			`MDG_FC_RD_INREG, `MDG_FC_RD_HOLDING, `MDG_FC_WR_REG, `MDG_FC_WR_REGS: begin
				next_word   = 1'b1;
				next_output = (i_req_func != `MDG_FC_RD_INREG);
				next_write  = (i_req_func == `MDG_FC_WR_REG) || (i_req_func == `MDG_FC_WR_REGS);
				if ((i_req_func == `MDG_FC_RD_INREG)
					&& in_range(i_req_ref, `MDG_REF_DIAG_LO, `MDG_REF_DIAG_HI)) begin
					offs      = i_req_ref - `MDG_REF_DIAG_LO;
					diag_idx  = offs[3:0];
					next_data = diag_word(diag_idx, cnt_bus, o_serial_link_diagnostics,
						o_vehicle_net_state, o_vehicle_net_faults);
				end else if (next_write && (i_req_ref == `MDG_REF_CLEAR)) begin
					next_data = i_req_data;
				end else if (!next_output
					&& in_range(i_req_ref, `MDG_REF_INREG_LO, `MDG_REF_INREG_HI)) begin
					offs      = i_req_ref - `MDG_REF_INREG_LO;
					next_byte = {offs[9:0], 1'b0};
					next_hit  = ({1'b0, next_byte} + 12'h001) < i_in_size;
				end else if (next_output
					&& in_range(i_req_ref, `MDG_REF_HOLD_LO, `MDG_REF_HOLD_HI)) begin
					offs      = i_req_ref - `MDG_REF_HOLD_LO;
					next_byte = {offs[9:0], 1'b0};
					next_hit  = ({1'b0, next_byte} + 12'h001) < i_out_size;
				end
				if (!next_hit && (diag_idx == `MDG_IDX_NONE)
					&& !(next_write && (i_req_ref == `MDG_REF_CLEAR))) begin
					next_exc      = 1'b1;
					next_exc_code = `MDG_EXC_ADDR;
				end
			end
			`MDG_FC_RD_COILS, `MDG_FC_RD_INPUTS, `MDG_FC_WR_COIL, `MDG_FC_WR_COILS: begin
				next_output = (i_req_func != `MDG_FC_RD_INPUTS);
				next_write  = (i_req_func == `MDG_FC_WR_COIL) || (i_req_func == `MDG_FC_WR_COILS);
				if (!next_output
					&& in_range(i_req_ref, `MDG_REF_INPUT_LO, `MDG_REF_INPUT_HI)) begin
					offs      = i_req_ref - `MDG_REF_INPUT_LO;
					next_byte = offs[13:3];
					next_bit  = offs[2:0];
					next_hit  = {1'b0, next_byte} < i_in_size;
				end else if (next_output
					&& in_range(i_req_ref, `MDG_REF_COIL_LO, `MDG_REF_COIL_HI)) begin
					offs      = i_req_ref - `MDG_REF_COIL_LO;
					next_byte = offs[13:3];
					next_bit  = offs[2:0];
					next_hit  = {1'b0, next_byte} < i_out_size;
				end
				if (!next_hit) begin
					next_exc      = 1'b1;
					next_exc_code = `MDG_EXC_ADDR;
				end
			end
			default: begin
				next_exc      = 1'b1;
				next_exc_code = `MDG_EXC_FUNC;
			end
		endcase
		if (next_exc) begin
			next_hit   = 1'b0;
			next_write = 1'b0;
		end
	end

	// response registers, valid for one enabled cycle
	always @(posedge i_mclk) begin
		if (i_reset) begin
			rsp_valid      <= 1'b0;
			o_rsp_exc      <= 1'b0;
			o_rsp_exc_code <= 8'h00;
			o_rsp_data     <= 16'h0000;
			o_tbl_hit      <= 1'b0;
			o_tbl_output   <= 1'b0;
			o_tbl_word     <= 1'b0;
			o_tbl_write    <= 1'b0;
			o_tbl_byte     <= 11'h000;
			o_tbl_bit      <= 3'h0;
			o_clear_done   <= 1'b0;
		end else if (i_ce) begin
			rsp_valid    <= i_req_valid;
			o_clear_done <= clear_req;
			if (i_req_valid) begin
				o_rsp_exc      <= next_exc;
				o_rsp_exc_code <= next_exc_code;
				o_rsp_data     <= next_data;
				o_tbl_hit      <= next_hit;
				o_tbl_output   <= next_output;
				o_tbl_word     <= next_word;
				o_tbl_write    <= next_write;
				o_tbl_byte     <= next_byte;
				o_tbl_bit      <= next_bit;
			end
		end
	end

	// answer strobe only while the clock enable runs
	assign o_rsp_valid = rsp_valid & i_ce;

endmodule

//--- dv/mdg_chk.sv
// port assertions for the diagnostic decoder and table address map
`timescale 1ns/1ns
module mdg_chk (
	input wire        i_mclk,
	input wire        i_reset,
	input wire        i_ce,
	input wire        i_req_valid,
	input wire [7:0]  i_req_func,
	input wire [15:0] i_req_ref,
	input wire [15:0] i_req_sub,
	input wire [15:0] i_req_data,
	input wire [11:0] i_in_size,
	input wire        i_can_busoff,
	input wire        i_active,
	input wire        i_master_alive,
	input wire        i_run_mode,
	input wire [1:0]  i_net_state,
	input wire        i_claim_failed,
	input wire        o_rsp_valid,
	input wire        o_rsp_exc,
	input wire [15:0] o_rsp_data,
	input wire        o_tbl_hit,
	input wire [10:0] o_tbl_byte,
	input wire        o_clear_done,
	input wire [15:0] o_serial_link_diagnostics,
	input wire [15:0] o_vehicle_net_state,
	input wire [15:0] o_vehicle_net_faults
);
	// taken request, diagnostic request, input register access and its byte offset
	wire        took  = i_req_valid & i_ce;
	wire        diag  = took & (i_req_func == 8'h08);
	wire        inreg = took & (i_req_func == 8'h04) & (i_req_ref >= 16'h7531)
		& (i_req_ref <= 16'h7930);
	wire [10:0] wbyte = {i_req_ref[9:0] - 10'h131, 1'b0};

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	rsp_follows_a: assert property (diag ##1 i_ce |-> o_rsp_valid)
		else $error("diagnostic request without answer");
	rsp_cause_a: assert property (o_rsp_valid |-> $past(took))
		else $error("answer without request");
	echo_data_a: assert property (diag && i_req_sub == 16'h0000 |=>
		o_rsp_data == $past(i_req_data) && !o_rsp_exc) else $error("echo data wrong");
	clear_faults_a: assert property (diag && i_req_sub == 16'h000A && !i_can_busoff |=>
		o_clear_done && !o_vehicle_net_faults[2]) else $error("clear not done");
	ser_bits_a: assert property (o_serial_link_diagnostics[15:7] == 9'h000 &&
		o_serial_link_diagnostics[2:0] == {i_run_mode, i_master_alive, i_active})
		else $error("serial word level bits wrong");
	net_state_a: assert property (o_vehicle_net_state == {14'h0000, i_net_state})
		else $error("network state word wrong");
	claim_bit_a: assert property (o_vehicle_net_faults[0] == i_claim_failed &&
		o_vehicle_net_faults[15:7] == 9'h000) else $error("fault word fixed bits wrong");
	busoff_latch_a: assert property (i_ce && i_can_busoff |=> o_vehicle_net_faults[2])
		else $error("bus-off fault not latched");
	word_hit_a: assert property (inreg |=> o_rsp_exc == !o_tbl_hit &&
		o_tbl_hit == ($past(wbyte) + 12'h001 < $past(i_in_size))) else $error("hit wrong");
	word_byte_a: assert property (inreg |=> o_tbl_hit |-> o_tbl_byte == $past(wbyte))
		else $error("word offset wrong");
endmodule

bind mdg_diag_map mdg_chk i_chk (.i_mclk, .i_reset, .i_ce, .i_req_valid, .i_req_func,
	.i_req_ref, .i_req_sub, .i_req_data, .i_in_size, .i_can_busoff, .i_active,
	.i_master_alive, .i_run_mode, .i_net_state, .i_claim_failed, .o_rsp_valid, .o_rsp_exc,
	.o_rsp_data, .o_tbl_hit, .o_tbl_byte, .o_clear_done, .o_serial_link_diagnostics,
	.o_vehicle_net_state, .o_vehicle_net_faults);

//--- dv/mdg_master.sv
// behavioural serial master issuing one decoded request at a time
`timescale 1ns/1ns
module mdg_master (
	input  wire        i_mclk,
	input  wire        i_rsp_valid,
	output reg         o_req_valid = 1'b0,
	output reg  [7:0]  o_req_func = 8'h00,
	output reg  [15:0] o_req_ref = 16'h0000,
	output reg  [15:0] o_req_sub = 16'h0000,
	output reg  [15:0] o_req_data = 16'h0000
);
	// drive after an edge, drop after the taking edge, then wait a bounded time
	task xfer(input [7:0] f, input [15:0] r, input [15:0] s, input [15:0] d, output ok);
		integer t;
		begin
			ok = 1'b0;
			@(posedge i_mclk);
			#1;
			o_req_valid = 1'b1;
			o_req_func = f;
			o_req_ref = r;
			o_req_sub = s;
			o_req_data = d;
			@(posedge i_mclk);
			#1;
			// released fields no longer carry the request
			o_req_valid = 1'b0;
			o_req_func = ~f;
			o_req_ref = ~r;
			o_req_sub = ~s;
			o_req_data = ~d;
			for (t = 0; t < 4 && !ok; t = t + 1) begin
				@(posedge i_mclk);
				ok = i_rsp_valid;
			end
			#1;
		end
	endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the diagnostic decoder and table address map
`timescale 1ns/1ns
module tb;
	reg         i_mclk = 1'b0;
	reg         i_reset = 1'b1;
	reg         i_ce = 1'b1;
	reg  [13:0] ev = 14'h0000;
	reg  [2:0]  lvl = 3'h0;
	reg  [1:0]  i_net_state = 2'h0;
	reg         i_claim_failed = 1'b0;
	reg  [11:0] i_in_size = 12'h000;
	reg  [11:0] i_out_size = 12'h000;
	wire        i_req_valid, o_rsp_valid, o_rsp_exc, o_tbl_hit, o_tbl_output, o_tbl_word;
	wire        o_tbl_write;
	wire [7:0]  i_req_func, o_rsp_exc_code;
	wire [15:0] i_req_ref, i_req_sub, i_req_data, o_rsp_data;
	wire [10:0] o_tbl_byte;
	wire [2:0]  o_tbl_bit;
	integer     err_total = 0, checked = 0, k, cnt [0:13];
	integer     subs [0:11] = '{2, 11, 12, 13, 14, 15, 18, 31, 32, 33, 34, 35};
	integer     sel [0:11] = '{0, 0, 2, 3, 1, 4, 5, 0, 0, 8, 9, 10};
	integer     fcs [0:7] = '{1, 2, 3, 4, 5, 6, 15, 16};

	always #10 i_mclk = ~i_mclk;

	// design, event pulses from one vector
	mdg_diag_map i_mdg_diag_map (
		.i_mclk, .i_reset, .i_ce, .i_req_valid, .i_req_func, .i_req_ref, .i_req_sub,
		.i_req_data, .i_in_size, .i_out_size, .i_frame_seen(ev[0]), .i_own_frame(ev[1]),
		.i_crc_err_own(ev[2]), .i_exc_sent(ev[3]), .i_no_resp(ev[4]), .i_ser_overrun(ev[5]),
		.i_parity_err(ev[6]), .i_framing_err(ev[7]), .i_can_warn(ev[8]),
		.i_can_busoff(ev[9]), .i_can_overrun(ev[10]), .i_tp_err(ev[11]), .i_rxq_ovf(ev[12]),
		.i_txq_ovf(ev[13]), .i_active(lvl[0]), .i_master_alive(lvl[1]), .i_run_mode(lvl[2]),
		.i_net_state, .i_claim_failed, .o_rsp_valid, .o_rsp_exc, .o_rsp_exc_code,
		.o_rsp_data, .o_tbl_hit, .o_tbl_output, .o_tbl_word, .o_tbl_write, .o_tbl_byte,
		.o_tbl_bit, .o_clear_done(), .o_serial_link_diagnostics(),
		.o_vehicle_net_state(), .o_vehicle_net_faults());

	mdg_master i_mst (.i_mclk, .i_rsp_valid(o_rsp_valid), .o_req_valid(i_req_valid),
		.o_req_func(i_req_func), .o_req_ref(i_req_ref), .o_req_sub(i_req_sub),
		.o_req_data(i_req_data));

	task final_report;
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task cmp(input [16:0] got, input [16:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one request, a lost answer ends the run
	task rq(input [7:0] f, input [15:0] r, input [15:0] s, input [15:0] d);
		reg ok;
		begin
			i_mst.xfer(f, r, s, d, ok);
			if (ok !== 1'b1) begin
				cmp(17'h0, 17'h1);
				final_report;
			end
		end
	endtask

	// model: sticky flag of an event line and expected diagnostic word
	function st(input integer i);
		st = (cnt[i] != 0);
	endfunction
	function [15:0] expw(input integer i);
		case (i)
			0: expw = {9'h000, st(2), st(7), st(6), st(5), lvl};
			7: expw = {14'h0000, i_net_state};
			8: expw = {9'h000, st(13), st(12), st(11), st(10), st(9), st(8), i_claim_failed};
			default: expw = cnt[sel[i]][15:0];
		endcase
	endfunction

	task clr;
		for (k = 0; k < 14; k = k + 1) cnt[k] = 0;
	endtask

	// every diagnostic word through function 8 and through the register window
	task read_all;
		integer i;
		for (i = 0; i < 12; i = i + 1) begin
			rq(8'h08, 16'h0000, subs[i], 16'h0000);
			cmp({o_rsp_exc, o_rsp_data}, {1'b0, expw(i)});
			rq(8'h04, 16'h7D01 + i, 16'h0000, 16'h0000);
			cmp({o_rsp_exc, o_rsp_data}, {1'b0, expw(i)});
		end
	endtask

	// random events and levels with the clock enable sometimes low
	task burst(input integer n);
		integer c, i;
		for (c = 0; c < n; c = c + 1) begin
			ev = $urandom;
			i_ce = ($urandom % 4) != 0;
			lvl = $urandom;
			i_net_state = $urandom % 3;
			i_claim_failed = $urandom;
			@(posedge i_mclk);
			if (i_ce)
				for (i = 0; i < 14; i = i + 1) if (ev[i]) cnt[i] = (cnt[i] + 1) % 65536;
			#1;
		end
		// quiet lines once the burst is over, never twice in one step
		ev = 14'h0000;
		i_ce = 1'b1;
	endtask

	// random table accesses of every function against the configured sizes
	task map_test;
		integer f, w, outp, wr, n, byt, h;
		repeat (300) begin
			i_in_size = $urandom % 2600;
			i_out_size = $urandom % 2600;
			f = fcs[$urandom % 8];
			w = (f == 3 || f == 4 || f == 6 || f == 16);
			outp = !(f == 2 || f == 4);
			wr = (f == 5 || f == 6 || f >= 15);
			n = w ? $urandom % 1024 + 1 : $urandom % 9999 + 1;
			byt = w ? 2 * (n - 1) : (n - 1) / 8;
			h = w ? byt + 1 < (outp ? i_out_size : i_in_size) : byt < (outp ? i_out_size : i_in_size);
			rq(f, n + (w ? (outp ? 40000 : 30000) : (outp ? 0 : 10000)), 16'h0000, $urandom);
			cmp({o_tbl_hit, o_rsp_exc}, {h[0], !h[0]});
			if (h) begin
				cmp({o_tbl_output, o_tbl_word, o_tbl_write, o_tbl_byte}, {outp[0], w[0], wr[0], byt[10:0]});
				if (!w) cmp(o_tbl_bit, (n - 1) % 8);
			end else
				cmp({o_rsp_exc_code, o_tbl_write}, {8'h02, 1'b0});
		end
	endtask

	initial begin
		clr;
		k = $urandom(32'h8C6A31FA);
		repeat (5) @(posedge i_mclk);
		#1;
		i_reset = 1'b0;
		read_all;
		burst(60);
		read_all;
		rq(8'h08, 16'h0000, 16'h000A, 16'h0000);
		cmp({o_rsp_exc, o_rsp_data}, {1'b0, 16'h0000});
		clr;
		read_all;
		burst(40);
		rq(8'h06, 16'hA411, 16'h0000, 16'h5A5A);
		cmp({o_rsp_exc, o_rsp_data}, {1'b0, 16'h5A5A});
		clr;
		read_all;
		burst(40);
		rq(8'h10, 16'hA411, 16'h0000, 16'hA5A5);
		cmp({o_rsp_exc, o_rsp_data}, {1'b0, 16'hA5A5});
		clr;
		burst(5);
		read_all;
		repeat (4) begin
			k = $urandom;
			rq(8'h08, 16'h0000, 16'h0000, k[15:0]);
			cmp({o_rsp_exc, o_rsp_data}, {1'b0, k[15:0]});
		end
		// bus message count held high past its maximum
		ev = 14'h0001;
		repeat (65537) @(posedge i_mclk);
		#1;
		ev = 14'h0000;
		cnt[0] = (cnt[0] + 65537) % 65536;
		rq(8'h08, 16'h0000, 16'h000B, 16'h0000);
		cmp(o_rsp_data, cnt[0]);
		// undecoded subfunction and function, then addresses outside the region of their function
		rq(8'h08, 16'h0000, 16'h0001, 16'h0000);
		cmp({o_rsp_exc, o_rsp_exc_code}, {1'b1, 8'h01});
		rq(8'h41, 16'h0001, 16'h0000, 16'h0000);
		cmp({o_rsp_exc, o_rsp_exc_code}, {1'b1, 8'h01});
		rq(8'h03, 16'h7D01, 16'h0000, 16'h0000);
		cmp({o_rsp_exc, o_rsp_exc_code, o_tbl_hit}, {1'b1, 8'h02, 1'b0});
		rq(8'h04, 16'h7D0D, 16'h0000, 16'h0000);
		cmp({o_rsp_exc, o_rsp_exc_code, o_tbl_hit}, {1'b1, 8'h02, 1'b0});
		rq(8'h01, 16'h2711, 16'h0000, 16'h0000);
		cmp({o_rsp_exc, o_rsp_exc_code, o_tbl_hit}, {1'b1, 8'h02, 1'b0});
		map_test;
		final_report;
	end
endmodule
